// File: common/hbp_pkg.sv
package hbp_pkg;

   // Bus style encodings on the style select pins.
   localparam logic [1:0] STYLE_GENERIC = 2'h0;
   localparam logic [1:0] STYLE_DSTROBE = 2'h1;
   localparam logic [1:0] STYLE_ECLOCK = 2'h2;

   // Addressing mode select levels.
   localparam logic MODE_INDIRECT = 1'h0;
   localparam logic MODE_DIRECT = 1'h1;

   // Widths of the host buses.
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;

   // Reset values of the sampled configuration.
   localparam logic [1:0] SHIFT_SEL_RST = 2'h0;
   localparam logic [1:0] STYLE_RST = 2'h0;
   localparam logic MODE_RST = 1'h0;

   // Internal access time seen by the host through the wait pin, in ns.
   localparam int ACCESS_NS = 16;
   localparam int CLK_PERIOD_NS = 4;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Pixel shift clock divide ratios per select code (half periods in clocks).
   localparam logic [3:0] SHIFT_HALF_0 = 4'h1;
   localparam logic [3:0] SHIFT_HALF_1 = 4'h2;
   localparam logic [3:0] SHIFT_HALF_2 = 4'h4;
   localparam logic [3:0] SHIFT_HALF_3 = 4'h8;

   // Sampled static configuration.
   typedef struct packed {
      logic [1:0] shift_sel;
      logic [1:0] style;
      logic mode;
   } hbp_cfg_t;

   // One accepted host access toward the core.
   typedef struct packed {
      logic write;
      logic is_param;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hbp_req_t;

endpackage : hbp_pkg

// File: verilog/hbp_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
module hbp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : hbp_sync

// File: verilog/hbp_port.sv
module hbp_port #(
   parameter int DW = hbp_pkg::DATA_W,
   parameter int AW = hbp_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Static configuration pins
   input wire logic [1:0] shift_clock_cycle_select,
   input wire logic [1:0] bus_style_select,
   input wire logic addressing_mode_select,
   // Host control pins
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [AW-1:0] host_addr,
   // Host data pins
   input wire logic [DW-1:0] data_in,
   output logic [DW-1:0] data_out,
   output logic data_oe,
   // Wait pin
   output logic wait_out,
   output logic wait_oe,
   // Core side
   output hbp_pkg::hbp_req_t req_r,
   output logic req_valid_r,
   input wire logic [DW-1:0] core_rdata,
   // Display shift clock
   output logic pixel_shift_clock,
   // Sampled configuration
   output hbp_pkg::hbp_cfg_t cfg_r
);

   typedef enum logic [1:0] {
      WT_IDLE,
      WT_HOLD,
      WT_DONE
   } hbp_wait_t;

   localparam int SW = 3 + AW + DW;

   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_s;
   logic cs_n_s;
   logic rd_s;
   logic wr_s;
   logic [AW-1:0] addr_s;
   logic [DW-1:0] din_s;
   logic rd_d_r;
   logic wr_d_r;
   logic cfg_done_r;
   logic [4:0] cfg_raw;
   logic [4:0] cfg_s;
   logic [1:0] settle_r;
   logic [DW-1:0] rdata_r;
   logic active;
   logic rd_dir;
   logic take;
   logic take_write;
   logic gen_rd;
   hbp_wait_t wst_r;
   logic [3:0] wcnt_r;
   logic [3:0] shift_cnt_r;
   logic [3:0] shift_half;

   // All asynchronous host pins pass two flops before any logic.
   assign pin_raw = {chip_select_n, read_strobe_n, write_strobe_n, host_addr, data_in};

   hbp_sync #(.W(SW)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .d(pin_raw),
      .q(pin_s)
   );

   assign {cs_n_s, rd_s, wr_s, addr_s, din_s} = pin_s;

   // The strap pins are static but still come from outside, so they get their own two flops.
   assign cfg_raw = {shift_clock_cycle_select, bus_style_select, addressing_mode_select};

   hbp_sync #(.W(5)) u_cfg_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .d(cfg_raw),
      .q(cfg_s)
   );

   // The synchronisers show reset levels for two clocks after release, so nothing trusts them before.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_r <= '0;
      end else if (settle_r != 2'h3) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   // Configuration is caught once the synchronised copies are real, then frozen.
   // Gating on cfg_done_r also keeps the stale strobe history from faking an edge after reset.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= '{hbp_pkg::SHIFT_SEL_RST, hbp_pkg::STYLE_RST, hbp_pkg::MODE_RST};
         cfg_done_r <= 1'b0;
      end else if (!cfg_done_r && settle_r == 2'h2) begin
         cfg_r.shift_sel <= cfg_s[4:3];
         cfg_r.style <= cfg_s[2:1];
         cfg_r.mode <= cfg_s[0];
         cfg_done_r <= 1'b1;
      end
   end

   // Previous strobe levels for edge detection on synchronised copies.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_d_r <= 1'b1;
         wr_d_r <= 1'b1;
      end else begin
         rd_d_r <= rd_s;
         wr_d_r <= wr_s;
      end
   end

   // Strobe decoding per bus style; the shared strobe means different things.
   always_comb begin
      active = 1'b0;
      rd_dir = 1'b0;
      take = 1'b0;
      take_write = 1'b0;
      gen_rd = 1'b0;
      unique case (cfg_r.style)
         hbp_pkg::STYLE_ECLOCK: begin
            active = rd_s;
            rd_dir = wr_s;
            take = rd_s && !rd_d_r;
            take_write = !wr_s;
         end
         hbp_pkg::STYLE_DSTROBE: begin
            active = !rd_s;
            rd_dir = wr_s;
            take = !rd_s && rd_d_r;
            take_write = !wr_s;
         end
         default: begin
            gen_rd = !rd_s;
            active = gen_rd;
            rd_dir = 1'b1;
            take = (!rd_s && rd_d_r) || (wr_s && !wr_d_r);
            take_write = wr_s && !wr_d_r;
         end
      endcase
      if (cs_n_s || !cfg_done_r) begin
         active = 1'b0;
         take = 1'b0;
      end
   end

   // Accepted access toward the core, one-cycle valid pulse.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_r <= '0;
         req_valid_r <= 1'b0;
      end else begin
         req_valid_r <= take;
         if (take) begin
            req_r.write <= take_write;
            req_r.is_param <= (cfg_r.mode == hbp_pkg::MODE_INDIRECT) && !addr_s[0];
            req_r.data <= din_s;
            if (cfg_r.mode == hbp_pkg::MODE_DIRECT) begin
               req_r.addr <= addr_s;
            end else begin
               req_r.addr <= {{(AW-1){1'b0}}, addr_s[0]};
            end
         end
      end
   end

   // Read data is held in a register so the pins never see core glitches.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= '0;
      end else if (take && !take_write) begin
         rdata_r <= core_rdata;
      end
   end

   // Drivers on only during an active read with chip select low.
   assign data_out = rdata_r;
   assign data_oe = rst_b && active && rd_dir && (cfg_r.style == hbp_pkg::STYLE_GENERIC ? gen_rd : 1'b1);

   // Wait handshake, generic bus only: low for the access time, high once, then released.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wst_r <= WT_IDLE;
         wcnt_r <= '0;
      end else begin
         unique case (wst_r)
            WT_IDLE: begin
               if (take && cfg_r.style == hbp_pkg::STYLE_GENERIC) begin
                  wst_r <= WT_HOLD;
                  wcnt_r <= 4'(hbp_pkg::ACCESS_CYC);
               end
            end
            WT_HOLD: begin
               if (wcnt_r <= 4'h1) begin
                  wst_r <= WT_DONE;
               end
               wcnt_r <= wcnt_r - 4'h1;
            end
            WT_DONE: begin
               wst_r <= WT_IDLE;
            end
         endcase
      end
   end

   assign wait_out = (wst_r == WT_DONE);
   assign wait_oe = (wst_r != WT_IDLE);

   // Pixel shift clock divider; the period follows the sampled select code.
   always_comb begin
      unique case (cfg_r.shift_sel)
         2'h0: shift_half = hbp_pkg::SHIFT_HALF_0;
         2'h1: shift_half = hbp_pkg::SHIFT_HALF_1;
         2'h2: shift_half = hbp_pkg::SHIFT_HALF_2;
         2'h3: shift_half = hbp_pkg::SHIFT_HALF_3;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_cnt_r <= '0;
         pixel_shift_clock <= 1'b0;
      end else if (shift_cnt_r + 4'h1 >= shift_half) begin
         shift_cnt_r <= '0;
         pixel_shift_clock <= !pixel_shift_clock;
      end else begin
         shift_cnt_r <= shift_cnt_r + 4'h1;
      end
   end

endmodule : hbp_port

// File: bench/hbp_port_asserts.sv
module hbp_port_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Host pins
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic data_oe,
   input wire logic wait_out,
   input wire logic wait_oe,
   // Core side and status
   input wire hbp_pkg::hbp_req_t req_r,
   input wire logic req_valid_r,
   input wire logic pixel_shift_clock,
   input wire hbp_pkg::hbp_cfg_t cfg_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain; early cycles are guarded because synchronisers still hold reset levels.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_cfg; $past(rst_b, 4) |-> $stable(cfg_r); endproperty
   a_cfg: assert property (p_cfg) else $error("cfg moved");
   property p_pulse; req_valid_r |=> !req_valid_r; endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_cs; chip_select_n [*5] |=> !req_valid_r; endproperty
   a_cs: assert property (p_cs) else $error("cs ignored");
   property p_wait; $rose(wait_oe) |-> !wait_out [*4] ##1 wait_out && wait_oe ##1 !wait_oe; endproperty
   a_wait: assert property (p_wait) else $error("wait shape");
   property p_wst; wait_oe |-> cfg_r.style[0] == cfg_r.style[1]; endproperty
   a_wst: assert property (p_wst) else $error("wait style");
   property p_oe; $past(rst_b, 3) && data_oe && cfg_r.style == 2'h0 |-> !$past(read_strobe_n, 2); endproperty
   a_oe: assert property (p_oe) else $error("oe no read");
   property p_par; req_valid_r && !cfg_r.mode |-> req_r.is_param == !req_r.addr[0]; endproperty
   a_par: assert property (p_par) else $error("type bit");
   property p_shf; $past(rst_b, 3) && $rose(pixel_shift_clock) && cfg_r.shift_sel == 2'h1
      |=> pixel_shift_clock ##1 !pixel_shift_clock; endproperty
   a_shf: assert property (p_shf) else $error("shift half");
   c_wait: cover property ($rose(wait_oe));
   c_par: cover property (req_valid_r && req_r.is_param);
   c_oe: cover property ($rose(data_oe));
endmodule : hbp_port_asserts
bind hbp_port hbp_port_asserts chk (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select_n(chip_select_n),
   .read_strobe_n(read_strobe_n), .data_oe(data_oe), .wait_out(wait_out), .wait_oe(wait_oe), .req_r(req_r),
   .req_valid_r(req_valid_r), .pixel_shift_clock(pixel_shift_clock), .cfg_r(cfg_r));

// File: bench/hbp_host.sv
module hbp_host (
   // Clock
   input wire logic ref_clk,
   // Host pins
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [15:0] a,
   output logic [7:0] dq
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cs_n, rd_n, wr_n, a, dq} = 27'h7000000;
   // Levels dwell long: the port synchronises pins and stretches with wait.
   task automatic xfer(input logic [1:0] st, input logic c, input logic w, input logic [15:0] ad,
      input logic [7:0] d);
      logic g;
      g = st[0] == st[1];
      @(posedge ref_clk);
      cs_n <= c;
      a <= ad;
      dq <= d;
      wr_n <= g | !w;
      rd_n <= st != hbp_pkg::STYLE_ECLOCK;
      repeat (4) @(posedge ref_clk);
      if (g && w) wr_n <= 1'b0;
      else rd_n <= !rd_n;
      repeat (10) @(posedge ref_clk);
      if (g && w) wr_n <= 1'b1;
      else rd_n <= !rd_n;
      repeat (4) @(posedge ref_clk);
      dq <= ~d; // Hold time over, so the old byte must not linger.
      cs_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask : xfer
endmodule : hbp_host

// File: bench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] sh = 2'h0;
   logic [1:0] st = 2'h0;
   logic md = 1'b0;
   logic [7:0] core_rdata = 8'h00;
   logic cs_n, rd_n, wr_n, data_oe, wait_out, wait_oe, req_valid_r, pixel_shift_clock;
   logic [15:0] a;
   logic [7:0] dq, data_out, seen;
   hbp_pkg::hbp_req_t req_r, got;
   hbp_pkg::hbp_cfg_t cfg_r;
   int fails = 0;
   int n_tests = 0;
   int nv = 0;
   int nw = 0;
   initial forever #2 ref_clk = ~ref_clk;
   hbp_host host (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a(a), .dq(dq));
   // The data wire shows the port's byte while it drives, else the host's.
   hbp_port uut (.shift_clock_cycle_select(sh), .bus_style_select(st), .addressing_mode_select(md),
      .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .host_addr(a),
      .data_in(data_oe ? data_out : dq), .ref_clk(ref_clk), .rst_b(rst_b), .data_out(data_out),
      .data_oe(data_oe), .wait_out(wait_out), .wait_oe(wait_oe), .req_r(req_r), .req_valid_r(req_valid_r),
      .core_rdata(core_rdata), .pixel_shift_clock(pixel_shift_clock), .cfg_r(cfg_r));
   // Keep the last access handed on and the last byte driven.
   always @(posedge ref_clk) begin
      if (req_valid_r === 1'b1) got <= req_r;
      if (req_valid_r === 1'b1) nv <= nv + 1;
      if (data_oe === 1'b1) seen <= data_out;
      if (wait_oe === 1'b1) nw <= nw + 1;
   end
   task automatic chk(input logic [25:0] g, input logic [25:0] e);
      n_tests++;
      if (g !== e) fails++;
      if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
   endtask : chk
   task automatic final_report;
      $display("checks %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   // Reset into a setup, then move the pins; the sampled setup must stay.
   task automatic boot(input logic [1:0] s, input logic m, input logic [1:0] h);
      int k;
      k = 0;
      @(posedge ref_clk);
      {rst_b, st, md, sh} <= {1'b0, s, m, h};
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      {st, md, sh} <= ~{s, m, h};
      @(negedge ref_clk);
      chk(cfg_r, {h, s, m});
      while (pixel_shift_clock !== 1'b0) @(negedge ref_clk);
      while (pixel_shift_clock !== 1'b1) @(negedge ref_clk);
      while (pixel_shift_clock === 1'b1 && k < 40) begin
         k++;
         @(negedge ref_clk);
      end
      chk(26'(k), 26'h1 << h);
      chk(cfg_r, {h, s, m});
   endtask : boot
   // Writes with both type bits in indirect mode, a read, then a read while deselected.
   task automatic run(input logic [1:0] s, input logic m, input logic [1:0] h);
      logic [15:0] ad;
      int n;
      int w0;
      boot(s, m, h);
      for (int i = 0; i < 2; i++) begin
         ad = m ? 16'ha5c2 | 16'(i) : 16'(i);
         n = nv;
         w0 = nw;
         host.xfer(s, 1'b0, 1'b1, ad, ad[7:0] ^ 8'h3c);
         chk(26'(nv - n), 26'h1);
         chk(26'(nw - w0), s == hbp_pkg::STYLE_GENERIC ? 26'(hbp_pkg::ACCESS_CYC + 1) : 26'h0);
         chk(got, {1'b1, !m && !ad[0], ad, ad[7:0] ^ 8'h3c});
      end
      core_rdata <= ad[7:0] ^ 8'h96;
      host.xfer(s, 1'b0, 1'b0, ad, 8'h00);
      chk(seen, ad[7:0] ^ 8'h96);
      chk(got.write, 1'b0);
      n = nv;
      core_rdata <= 8'h00;
      host.xfer(s, 1'b1, 1'b0, ad, 8'h00);
      chk(26'(nv - n), 26'h0);
      chk(seen, ad[7:0] ^ 8'h96);
   endtask : run
   initial begin
      run(hbp_pkg::STYLE_GENERIC, hbp_pkg::MODE_INDIRECT, 2'h0);
      run(hbp_pkg::STYLE_ECLOCK, hbp_pkg::MODE_DIRECT, 2'h1);
      run(hbp_pkg::STYLE_DSTROBE, hbp_pkg::MODE_INDIRECT, 2'h2);
      run(hbp_pkg::STYLE_GENERIC, hbp_pkg::MODE_DIRECT, 2'h3);
      final_report;
   end
   // Runs take about 550 clocks; a hang is cut well beyond that.
   initial begin
      repeat (4000) @(posedge ref_clk);
      fails++;
      final_report;
   end
endmodule : tb_top
